// ---- verilog/eebac_pkg.sv ----
// Shared constants for the byte EEPROM access controller and its driver
`default_nettype none
package eebac_pkg;
  // I/O register offsets of the storage end
  localparam logic [5:0] IO_CTRL = 6'h1C;
  localparam logic [5:0] IO_DATA = 6'h1D;
  localparam logic [5:0] IO_ADDR_LO = 6'h1E;
  localparam logic [5:0] IO_ADDR_HI = 6'h1F;
  localparam logic [5:0] IO_EV_STATUS = 6'h0E;
  localparam logic [5:0] IO_EV_MASK = 6'h0F;
  // Control register bit positions
  localparam int unsigned CTRL_READ = 0;
  localparam int unsigned CTRL_GO = 1;
  localparam int unsigned CTRL_ARM = 2;
  localparam int unsigned CTRL_RIE = 3;
  localparam int unsigned CTRL_MODE_LO = 4;
  // Event status bit positions
  localparam int unsigned EV_PROG_DONE = 0;
  localparam int unsigned EV_READ_DONE = 1;
  // Programming mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  // Reset values and widths
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DEPTH_DEF = 512;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Timing in CPU clock cycles
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;
  // Programming times, counted in calibrated oscillator ticks
  localparam real ATOMIC_MS = 3.4;
  localparam real SPLIT_MS = 1.8;
  localparam real OSC_TICK_US = 1.0;
  localparam int unsigned ATOMIC_TICKS =
    int'(ATOMIC_MS * 1000.0 / OSC_TICK_US);
  localparam int unsigned SPLIT_TICKS = int'(SPLIT_MS * 1000.0 / OSC_TICK_US);
  // Driver register offsets and command bits
  localparam logic [2:0] SW_ADDR_LO = 3'h0;
  localparam logic [2:0] SW_ADDR_HI = 3'h1;
  localparam logic [2:0] SW_DATA = 3'h2;
  localparam logic [2:0] SW_CMD = 3'h3;
  localparam logic [2:0] SW_STATUS = 3'h4;
  localparam logic [2:0] SW_RESULT = 3'h5;
  localparam int unsigned CMD_MODE_LO = 0;
  localparam int unsigned CMD_READ = 2;
  localparam int unsigned CMD_RIE = 3;
endpackage
`default_nettype wire

// ---- verilog/eebac_if.sv ----
// I/O register link between the CPU-side driver and the EEPROM end
`default_nettype none
interface eebac_if;
  logic [5:0] io_addr;  // Register offset
  logic [7:0] io_wdata; // Write data
  logic io_we;          // Write strobe
  logic io_re;          // Read strobe
  logic [7:0] io_rdata; // Read data, cycle after io_re
  logic io_stall;       // CPU halt request
  modport dev (input io_addr, io_wdata, io_we, io_re,
               output io_rdata, io_stall);
  modport host (output io_addr, io_wdata, io_we, io_re,
                input io_rdata, io_stall);
endinterface
`default_nettype wire

// ---- verilog/eebac_dev.sv ----
// EEPROM end: I/O registers, timed programming and byte storage
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Byte storage of 128, 256 or 512
// - Address, data, control live in I/O space
// - Read trigger stalls CPU four cycles
// - Program trigger stalls CPU two cycles
// - Mode 00 armed go: erase plus write
// - Go bit stays set until done
// - Busy refuses reads, programs, address changes
// - Mode 01 armed go: erase only
// - Mode 10 armed go: write only
// - Write only needs previously erased byte
// - Programming time from calibrated oscillator
// - Reset does not abort running program
// - Software polls go bit before access
// - Read trigger loads addressed byte into data
// - Arm bit self-clears after four cycles
// - Mode writes ignored while go set
// - Times: 3.4 ms atomic, 1.8 ms split
// - Ready interrupt level while not busy
module eebac_dev #(
  parameter int unsigned DEPTH = eebac_pkg::DEPTH_DEF,
  parameter int unsigned ATOMIC_TICKS = eebac_pkg::ATOMIC_TICKS,
  parameter int unsigned SPLIT_TICKS = eebac_pkg::SPLIT_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // I/O register link
  eebac_if.dev io,
  // Oscillator and CPU status
  input wire logic osc_tick_i,
  input wire logic gie_i,
  // Status outputs
  output logic irq_o,
  output logic busy_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(ATOMIC_TICKS + 1);

  // Duration of an operation in oscillator ticks
  function automatic logic [TW-1:0] prog_ticks(input logic [1:0] m);
    prog_ticks = (m == eebac_pkg::MODE_ATOMIC) ? TW'(ATOMIC_TICKS)
                                               : TW'(SPLIT_TICKS);
  endfunction

  // Control register readback image
  function automatic logic [7:0] ctrl_image(input logic [1:0] m,
                                            input logic ie,
                                            input logic armed,
                                            input logic bsy);
    ctrl_image = (8'(m) << eebac_pkg::CTRL_MODE_LO)
               | (8'(ie) << eebac_pkg::CTRL_RIE)
               | (8'(armed) << eebac_pkg::CTRL_ARM)
               | (8'(bsy) << eebac_pkg::CTRL_GO);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage and state
  logic [7:0] mem [DEPTH];     // Byte array, not reset: nonvolatile
  logic [1:0] mode;            // program_mode_field
  logic rie;                   // ready_irq_enable
  logic [2:0] arm_cnt;         // program_arm window, nonzero = set
  logic [2:0] stall_cnt;       // Remaining CPU halt cycles
  logic [8:0] addr;            // nv_byte_address
  logic [7:0] data;            // nv_data_byte
  logic [7:0] ev_status;       // Sticky events
  logic [7:0] ev_mask;         // Event interrupt mask
  logic [7:0] rdata;           // Registered read data
  logic irq;                   // Registered interrupt
  logic stall, next_stall;     // Registered halt level
  // Power-up values model the idle array; reset must not touch these
  logic busy = 1'b0;           // program_go_busy
  logic [TW-1:0] tick_cnt = '0;
  logic [1:0] op_mode = eebac_pkg::MODE_ATOMIC;
  logic [8:0] op_addr = eebac_pkg::ADDR_RST;
  logic [7:0] op_data = eebac_pkg::DATA_RST;
  // Oscillator tick synchroniser, free running through reset
  logic osc_meta = 1'b0;
  logic osc_sync = 1'b0;
  logic osc_prev = 1'b0;

  // Next values
  logic [1:0] next_mode;
  logic next_rie;
  logic [2:0] next_arm_cnt;
  logic [2:0] next_stall_cnt;
  logic [8:0] next_addr;
  logic [7:0] next_data;
  logic [7:0] next_ev_status;
  logic [7:0] next_ev_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic next_busy;
  logic [TW-1:0] next_tick_cnt;
  logic [1:0] next_op_mode;
  logic [8:0] next_op_addr;
  logic [7:0] next_op_data;
  logic commit;                // Store result into the array
  logic [7:0] commit_val;      // Byte to store

  // Decoded accesses, blocked while reset holds
  logic wr_ctrl, wr_data, wr_lo, wr_hi, wr_stat, wr_mask;
  logic tick_rise, go_ok, rd_ok, done;
  logic [7:0] ev_set;

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator tick crossing: second stage feeds the edge detector only
  always_ff @(posedge mclk_i) begin
    osc_meta <= osc_tick_i;
    osc_sync <= osc_meta;
    osc_prev <= osc_sync;
  end
  assign tick_rise = osc_sync & ~osc_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Access decode
  always_comb begin
    wr_ctrl = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_CTRL);
    wr_data = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_DATA);
    wr_lo = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_ADDR_LO);
    wr_hi = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_ADDR_HI);
    wr_stat = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_EV_STATUS);
    wr_mask = io.io_we & ~rst_i & (io.io_addr == eebac_pkg::IO_EV_MASK);
    // Go needs an open arm window, idle array and a defined mode
    go_ok = wr_ctrl & io.io_wdata[eebac_pkg::CTRL_GO] & (arm_cnt != 3'h0)
          & ~busy
          & (io.io_wdata[eebac_pkg::CTRL_MODE_LO +: 2]
             != eebac_pkg::MODE_RSVD);
    rd_ok = wr_ctrl & io.io_wdata[eebac_pkg::CTRL_READ] & ~busy;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Programming engine: start, oscillator timing, completion
  always_comb begin
    next_busy = busy;
    next_tick_cnt = tick_cnt;
    next_op_mode = op_mode;
    next_op_addr = op_addr;
    next_op_data = op_data;
    commit = 1'b0;
    commit_val = op_data;
    done = 1'b0;
    if (go_ok) begin
      // Latch the job so later register writes cannot disturb it
      next_busy = 1'b1;
      next_tick_cnt = '0;
      next_op_mode = io.io_wdata[eebac_pkg::CTRL_MODE_LO +: 2];
      next_op_addr = addr;
      next_op_data = data;
    end else if (busy && tick_rise) begin
      // Counts oscillator ticks, never CPU cycles
      if (tick_cnt == prog_ticks(op_mode) - TW'(1)) begin
        next_busy = 1'b0;
        done = 1'b1;
        commit = 1'b1;
      end else begin
        next_tick_cnt = tick_cnt + TW'(1);
      end
    end
    unique case (op_mode)
      eebac_pkg::MODE_ATOMIC: commit_val = op_data;
      eebac_pkg::MODE_ERASE: commit_val = eebac_pkg::ERASED_BYTE;
      // Only clears bits: an unerased byte ends up corrupt
      eebac_pkg::MODE_WRITE:
        commit_val = mem[op_addr[AW-1:0]] & op_data;
      default: commit_val = mem[op_addr[AW-1:0]];
    endcase
  end

  // Engine state ignores reset so a running job completes
  always_ff @(posedge mclk_i) begin
    busy <= next_busy;
    tick_cnt <= next_tick_cnt;
    op_mode <= next_op_mode;
    op_addr <= next_op_addr;
    op_data <= next_op_data;
  end

  // Array write at the end of an operation
  always_ff @(posedge mclk_i) begin
    if (commit) begin
      mem[op_addr[AW-1:0]] <= commit_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file, stall and interrupt
  always_comb begin
    next_mode = mode;
    next_rie = rie;
    next_addr = addr;
    next_data = data;
    next_rdata = 8'h00;
    // Arm window counts down on its own
    next_arm_cnt = (arm_cnt == 3'h0) ? 3'h0 : arm_cnt - 3'h1;
    next_stall_cnt = (stall_cnt == 3'h0) ? 3'h0 : stall_cnt - 3'h1;
    if (wr_ctrl) begin
      next_rie = io.io_wdata[eebac_pkg::CTRL_RIE];
      if (!busy) begin
        next_mode = io.io_wdata[eebac_pkg::CTRL_MODE_LO +: 2];
      end
      if (io.io_wdata[eebac_pkg::CTRL_ARM]) begin
        next_arm_cnt = eebac_pkg::ARM_WINDOW;
      end
    end
    if (go_ok) begin
      next_stall_cnt = eebac_pkg::PROG_STALL;
    end
    if (rd_ok) begin
      // Data is ready for the instruction after the halt
      next_data = mem[addr[AW-1:0]];
      next_stall_cnt = eebac_pkg::READ_STALL;
    end else if (wr_data) begin
      next_data = io.io_wdata;
    end
    // Address frozen while programming; unused high bits stay zero
    if (wr_lo && !busy) begin
      next_addr = {addr[8], io.io_wdata} & 9'(DEPTH - 1);
    end
    if (wr_hi && !busy) begin
      next_addr = {io.io_wdata[0], addr[7:0]} & 9'(DEPTH - 1);
    end
    // Sticky events: a new event beats a same-cycle clear
    ev_set = (8'(done) << eebac_pkg::EV_PROG_DONE)
           | (8'(rd_ok) << eebac_pkg::EV_READ_DONE);
    next_ev_status = ev_status;
    if (wr_stat) begin
      next_ev_status = ev_status & ~io.io_wdata;
    end
    next_ev_status = next_ev_status | ev_set;
    next_ev_mask = wr_mask ? io.io_wdata : ev_mask;
    // Halt level taken from a flop so the link never sees a glitch
    next_stall = (next_stall_cnt != 3'h0);
    // Readback, one cycle after the strobe
    if (io.io_re && !rst_i) begin
      unique case (io.io_addr)
        eebac_pkg::IO_CTRL:
          next_rdata = ctrl_image(mode, rie, arm_cnt != 3'h0, busy);
        eebac_pkg::IO_DATA: next_rdata = data;
        eebac_pkg::IO_ADDR_LO: next_rdata = addr[7:0];
        eebac_pkg::IO_ADDR_HI: next_rdata = {7'h00, addr[8]};
        eebac_pkg::IO_EV_STATUS: next_rdata = ev_status;
        eebac_pkg::IO_EV_MASK: next_rdata = ev_mask;
        default: next_rdata = 8'h00;
      endcase
    end
    // Ready level plus masked sticky events
    next_irq = (rie & gie_i & ~busy)
             | (|(ev_status & ev_mask));
  end

  // Register file update; mode survives reset only during a job
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      if (!busy) begin
        mode <= eebac_pkg::MODE_ATOMIC;
      end
      rie <= 1'b0;
      arm_cnt <= 3'h0;
      stall_cnt <= 3'h0;
      addr <= eebac_pkg::ADDR_RST;
      data <= eebac_pkg::DATA_RST;
      ev_status <= 8'h00;
      ev_mask <= eebac_pkg::MASK_RST;
      rdata <= 8'h00;
      irq <= 1'b0;
      stall <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      mode <= next_mode;
      rie <= next_rie;
      arm_cnt <= next_arm_cnt;
      stall_cnt <= next_stall_cnt;
      addr <= next_addr;
      data <= next_data;
      ev_status <= next_ev_status;
      ev_mask <= next_ev_mask;
      rdata <= next_rdata;
      irq <= next_irq;
      stall <= next_stall;
      busy_o <= next_busy;
    end
  end

  // Outputs, all from flip-flops
  assign io.io_rdata = rdata;
  assign io.io_stall = stall;
  assign irq_o = irq;
endmodule
`default_nettype wire

// ---- verilog/eebac_host.sv ----
// CPU-side driver: runs read and timed programming sequences
`default_nettype none
module eebac_host (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Software port
  input wire logic [2:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_we_i,
  input wire logic sw_re_i,
  output logic [7:0] sw_rdata_o,
  // I/O register link
  eebac_if.host io
);
  // Sequencer states
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_POLL = 10'h002, S_PWAIT = 10'h004,
    S_PCHK = 10'h008, S_STEP = 10'h010, S_SETTLE = 10'h020,
    S_HOLD = 10'h040, S_FETCH = 10'h080, S_FWAIT = 10'h100,
    S_CATCH = 10'h200
  } eebac_hstate_t;

  // Offset and data for each write step of a sequence
  function automatic logic [13:0] step_word(input logic [2:0] s,
                                            input logic [3:0] c,
                                            input logic [8:0] a,
                                            input logic [7:0] d);
    logic [7:0] base;
    base = (8'(c[eebac_pkg::CMD_MODE_LO +: 2]) << eebac_pkg::CTRL_MODE_LO)
         | (8'(c[eebac_pkg::CMD_RIE]) << eebac_pkg::CTRL_RIE);
    unique case (s)
      3'h0: step_word = {eebac_pkg::IO_CTRL, base};
      3'h1: step_word = {eebac_pkg::IO_ADDR_HI, {7'h00, a[8]}};
      3'h2: step_word = {eebac_pkg::IO_ADDR_LO, a[7:0]};
      3'h3: step_word = {eebac_pkg::IO_DATA, d};
      3'h4: step_word = {eebac_pkg::IO_CTRL,
                         base | (8'h01 << eebac_pkg::CTRL_ARM)};
      3'h5: step_word = {eebac_pkg::IO_CTRL,
                         base | (8'h01 << eebac_pkg::CTRL_GO)};
      default: step_word = {eebac_pkg::IO_CTRL,
                            base | (8'h01 << eebac_pkg::CTRL_READ)};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State
  eebac_hstate_t state, next_state;
  logic [2:0] step, next_step;     // Write step index
  logic [8:0] req_addr, next_req_addr;
  logic [7:0] req_data, next_req_data;
  logic [3:0] cmd, next_cmd;       // Mode, read flag, irq enable
  logic [7:0] result, next_result; // Last byte read
  logic valid, next_valid;         // Result holds fresh data
  logic [5:0] oa, next_oa;
  logic [7:0] owd, next_owd;
  logic owe, next_owe, ore, next_ore;
  logic [7:0] srd, next_srd;
  logic [13:0] sw_word;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and software registers
  always_comb begin
    next_state = state;
    next_step = step;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_cmd = cmd;
    next_result = result;
    next_valid = valid;
    next_oa = oa;
    next_owd = 8'h00;
    next_owe = 1'b0;
    next_ore = 1'b0;
    next_srd = 8'h00;
    sw_word = step_word(step, cmd, req_addr, req_data);
    // Parameter writes, ignored while a sequence runs
    if (sw_we_i && state == S_IDLE) begin
      unique case (sw_addr_i)
        eebac_pkg::SW_ADDR_LO: next_req_addr[7:0] = sw_wdata_i;
        eebac_pkg::SW_ADDR_HI: next_req_addr[8] = sw_wdata_i[0];
        eebac_pkg::SW_DATA: next_req_data = sw_wdata_i;
        eebac_pkg::SW_CMD: begin
          next_cmd = sw_wdata_i[3:0];
          next_valid = 1'b0;
          next_state = S_POLL;
        end
        default: begin
        end
      endcase
    end
    if (sw_re_i) begin
      unique case (sw_addr_i)
        eebac_pkg::SW_ADDR_LO: next_srd = req_addr[7:0];
        eebac_pkg::SW_ADDR_HI: next_srd = {7'h00, req_addr[8]};
        eebac_pkg::SW_DATA: next_srd = req_data;
        eebac_pkg::SW_CMD: next_srd = {4'h0, cmd};
        eebac_pkg::SW_STATUS: next_srd = {6'h00, valid, state != S_IDLE};
        eebac_pkg::SW_RESULT: next_srd = result;
        default: next_srd = 8'h00;
      endcase
    end
    unique case (state)
      S_IDLE: begin
      end
      // Busy poll of the control register
      S_POLL: begin
        next_oa = eebac_pkg::IO_CTRL;
        next_ore = 1'b1;
        next_state = S_PWAIT;
      end
      S_PWAIT: next_state = S_PCHK;
      S_PCHK: begin
        if (io.io_rdata[eebac_pkg::CTRL_GO]) begin
          next_state = S_POLL;
        end else begin
          next_step = 3'h0;
          next_state = S_STEP;
        end
      end
      // Back-to-back writes keep go inside the arm window
      S_STEP: begin
        {next_oa, next_owd} = sw_word;
        next_owe = 1'b1;
        if (cmd[eebac_pkg::CMD_READ] && step == 3'h2) begin
          next_step = 3'h6;
        end else if (step == 3'h5 || step == 3'h6) begin
          next_state = S_SETTLE;
        end else begin
          next_step = step + 3'h1;
        end
      end
      S_SETTLE: next_state = S_HOLD;
      // Wait out the halt before the next access
      S_HOLD: begin
        if (!io.io_stall) begin
          next_state = cmd[eebac_pkg::CMD_READ] ? S_FETCH : S_IDLE;
        end
      end
      S_FETCH: begin
        next_oa = eebac_pkg::IO_DATA;
        next_ore = 1'b1;
        next_state = S_FWAIT;
      end
      S_FWAIT: next_state = S_CATCH;
      S_CATCH: begin
        next_result = io.io_rdata;
        next_valid = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Registers; write-only on an unerased byte is the caller's risk
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      step <= 3'h0;
      req_addr <= eebac_pkg::ADDR_RST;
      req_data <= eebac_pkg::DATA_RST;
      cmd <= 4'h0;
      result <= 8'h00;
      valid <= 1'b0;
      oa <= 6'h00;
      owd <= 8'h00;
      owe <= 1'b0;
      ore <= 1'b0;
      srd <= 8'h00;
    end else begin
      state <= next_state;
      step <= next_step;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      cmd <= next_cmd;
      result <= next_result;
      valid <= next_valid;
      oa <= next_oa;
      owd <= next_owd;
      owe <= next_owe;
      ore <= next_ore;
      srd <= next_srd;
    end
  end

  // Outputs from flip-flops
  assign io.io_addr = oa;
  assign io.io_wdata = owd;
  assign io.io_we = owe;
  assign io.io_re = ore;
  assign sw_rdata_o = srd;
endmodule
`default_nettype wire

// ---- verif/eebac_asserts.sv ----
// Concurrent checks on the link between driver and storage end
`default_nettype none
module eebac_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_rdata,
  input wire logic io_stall,
  // Storage end job level
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Any write to the control register
  logic ctrl_wr;
  assign ctrl_wr = io_we && io_addr == eebac_pkg::IO_CTRL;
  // Arm alone; a combined arm and go is refused by the device unless an arm window is already open
  sequence arm_s;
    ctrl_wr && io_wdata[eebac_pkg::CTRL_ARM] && !io_wdata[eebac_pkg::CTRL_GO];
  endsequence
  // Go with a usable mode while idle
  sequence go_ok_s;
    ctrl_wr && io_wdata[eebac_pkg::CTRL_GO] && !busy_o &&
      io_wdata[5:4] != eebac_pkg::MODE_RSVD;
  endsequence
  // Go with the reserved mode code
  sequence go_bad_s;
    ctrl_wr && io_wdata[eebac_pkg::CTRL_GO] && !busy_o &&
      io_wdata[5:4] == eebac_pkg::MODE_RSVD;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  read_stall_a: assert property (
    ctrl_wr && io_wdata[eebac_pkg::CTRL_READ] && !busy_o && !io_stall
    |=> io_stall [*4] ##1 !io_stall)
    else $error("read trigger stall is not four cycles");
  prog_stall_a: assert property (arm_s ##1 go_ok_s |=>
    io_stall [*2] ##1 !io_stall)
    else $error("program trigger stall is not two cycles");
  prog_busy_a: assert property (arm_s ##1 go_ok_s |=> busy_o [*8])
    else $error("busy not held after accepted go");
  rsvd_mode_a: assert property (arm_s ##1 go_bad_s |=>
    (!io_stall && !busy_o) [*4])
    else $error("reserved mode started a job");
  stall_quiet_a: assert property (io_stall |-> !io_we && !io_re)
    else $error("request issued during stall");
  stall_cause_a: assert property ($rose(io_stall) |-> $past(ctrl_wr))
    else $error("stall without a control write");
  rdata_idle_a: assert property (!$past(io_re) |-> io_rdata == 8'h00)
    else $error("read data outside its cycle");
  strobe_excl_a: assert property (!(io_we && io_re))
    else $error("both strobes at once");
endmodule
`default_nettype wire

// ---- verif/eebac_bench.sv ----
// Self-checking bench joining the driver and the storage end
`default_nettype none
module eebac_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned AT = 8; // Short atomic job, oscillator ticks
  localparam int unsigned SP = 4; // Short split job, oscillator ticks
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc = 1'b0; // Oscillator tick, 1 us period
  logic gie = 1'b1; // Global interrupt enable
  logic [2:0] sa = 3'h0;
  logic [7:0] swd = 8'h00;
  logic swe = 1'b0;
  logic sre = 1'b0;
  logic [7:0] srd;
  logic irq;
  logic busy;
  logic [7:0] v; // Last software read value
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int bcnt = 0; // Cycles seen with the job busy
  eebac_if link ();
  eebac_dev #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(SP)) eebac_dev_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .io(link), .osc_tick_i(osc),
    .gie_i(gie), .irq_o(irq), .busy_o(busy));
  eebac_host eebac_host_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .sw_addr_i(sa), .sw_wdata_i(swd), .sw_we_i(swe), .sw_re_i(sre),
    .sw_rdata_o(srd), .io(link));
  eebac_asserts eebac_asserts_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .io_addr(link.io_addr), .io_wdata(link.io_wdata), .io_we(link.io_we),
    .io_re(link.io_re), .io_rdata(link.io_rdata), .io_stall(link.io_stall),
    .busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////
  // Clocks; ticks change on falling edges, away from sampling
  always #50 mclk_i = ~mclk_i;
  always #500 osc = ~osc;
  // Busy tally and hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end
    if (cyc == 6000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle write strobe, a gap follows
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sa <= a;
    swd <= d;
    swe <= 1'b1;
    @(posedge mclk_i);
    swe <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    sa <= a;
    sre <= 1'b1;
    @(posedge mclk_i);
    sre <= 1'b0;
    #1 v = srd;
  endtask
  // Wait for the job level to fall, then the driver to go idle
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    rd(eebac_pkg::SW_STATUS);
    while (v[0] !== 1'b0 && n < 2500) begin
      rd(eebac_pkg::SW_STATUS);
      n++;
    end
  endtask
  task automatic op(input logic [8:0] a, input logic [7:0] d,
                    input logic [7:0] c);
    wr(eebac_pkg::SW_ADDR_LO, a[7:0]);
    wr(eebac_pkg::SW_ADDR_HI, {7'h00, a[8]});
    wr(eebac_pkg::SW_DATA, d);
    wr(eebac_pkg::SW_CMD, c);
  endtask
  // Read a byte back through the driver, ready irq kept enabled
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    op(a, 8'h00, 8'h0C);
    idle();
    rd(eebac_pkg::SW_RESULT);
    chk("read byte", {8'h00, e}, {8'h00, v});
  endtask
  // Program, timing the busy level against t ticks of 10 cycles
  task automatic prog(input logic [8:0] a, input logic [7:0] d,
                      input logic [1:0] m, input int t);
    int b0;
    int n;
    b0 = bcnt;
    n = 0;
    op(a, d, 8'h08 | {6'h00, m});
    while (busy !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (3) @(posedge mclk_i);
    #1 chk("irq in job", {15'h0000, t == 0}, {15'h0000, irq});
    idle();
    n = bcnt - b0;
    chk("busy time", 16'h0001,
        {15'h0000, n >= t * 10 - 12 && n <= t * 10 + 12});
    repeat (2) @(posedge mclk_i);
    #1 chk("irq ready", 16'h0001, {15'h0000, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    prog(9'h1A5, 8'h3C, eebac_pkg::MODE_ATOMIC, AT);
    rchk(9'h1A5, 8'h3C);
    prog(9'h1A5, 8'h00, eebac_pkg::MODE_ERASE, SP);
    rchk(9'h1A5, eebac_pkg::ERASED_BYTE);
    prog(9'h1A5, 8'h5A, eebac_pkg::MODE_WRITE, SP);
    rchk(9'h1A5, 8'h5A);
    prog(9'h1A5, 8'h11, eebac_pkg::MODE_RSVD, 0);
    rchk(9'h1A5, 8'h5A);
    prog(9'h0A5, 8'h99, eebac_pkg::MODE_ATOMIC, AT);
    rchk(9'h1A5, 8'h5A);
    rchk(9'h0A5, 8'h99);
    @(posedge mclk_i);
    gie <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 chk("irq masked", 16'h0000, {15'h0000, irq});
    // Reset lands in mid-job; the byte must still be written
    op(9'h033, 8'h77, 8'h08);
    repeat (30) @(posedge mclk_i);
    #1 chk("busy before reset", 16'h0001, {15'h0000, busy});
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 chk("busy in reset", 16'h0000, {15'h0000, busy});
    @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(9'h033, 8'h77);
    tally_and_finish();
  end
endmodule
`default_nettype wire
